//--- hw/sdram_ca_defines.svh
`ifndef SDRAM_CA_DEFINES_SVH
`define SDRAM_CA_DEFINES_SVH

// =====================================================================
// Command codes on {row strobe, column strobe, write enable}
`define CA_CODE_MRS 3'h0
`define CA_CODE_REF 3'h1
`define CA_CODE_PRE 3'h2
`define CA_CODE_WR 3'h4
`define CA_CODE_RD 3'h5
`define CA_CODE_ZQ 3'h6
`define CA_CODE_NOP 3'h7

// =====================================================================
// Mode register selection and field layout
`define CA_MR1_SEL 3'h1
`define CA_RTT_LSB 8
`define CA_RTT_W 3
`define CA_TDQS_BIT 11
`define CA_AUTO_CLOSE_BIT 10
`define CA_BURST_CHOP_BIT 12

// =====================================================================
// Bank tracking
`define CA_IDX_W 4
`define CA_NBANK 16
`define CA_AUTO_CLOSE_CYC 3'h4

`endif

//--- hw/ca_decode_pkg.sv
package ca_decode_pkg;

    // =================================================================
    // Decoded commands
    typedef enum logic [3:0] {
        CMD_NONE, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT,
        CMD_WR, CMD_RD, CMD_ZQ, CMD_NOP, CMD_RSVD
    } cmd_t;

    // =================================================================
    // Clock-gating power states
    typedef enum logic [1:0] {
        PWR_ACTIVE, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF
    } pwr_t;

endpackage

//--- hw/bank_if.sv
`timescale 1ns/1ps
`include "sdram_ca_defines.svh"

// =====================================================================
// Open-row bookkeeping between decoder and bank tracker
interface bank_if;
    logic act_ev;
    logic pre_ev;
    logic pre_all;
    logic sched_ev;
    logic [`CA_IDX_W-1:0] idx;
    logic all_idle;
    logic [`CA_NBANK-1:0] open_mask;

    modport ctrl (output act_ev, output pre_ev, output pre_all, output sched_ev,
                  output idx, input all_idle, input open_mask);
    modport trk (input act_ev, input pre_ev, input pre_all, input sched_ev,
                 input idx, output all_idle, output open_mask);
endinterface

//--- hw/bank_tracker.sv
`timescale 1ns/1ps
`include "sdram_ca_defines.svh"

// =====================================================================
// Per-bank open-row flags with delayed auto-close
module bank_tracker #(
    parameter int NBANK = `CA_NBANK
) (
    input wire logic clk,
    input wire logic nrst,
    bank_if.trk b
);
    genvar g;

    generate
        for (g = 0; g < NBANK; g++) begin : g_bank
            logic open_r;
            logic [2:0] cnt_r;
            wire hit = (b.idx == `CA_IDX_W'(g));
            wire close_now = (b.pre_ev & (b.pre_all | hit)) | (cnt_r == 3'h1);

            // Activate wins over any pending close of the same bank
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    open_r <= 1'b0;
                    cnt_r <= 3'h0;
                end else if (b.act_ev & hit) begin
                    open_r <= 1'b1;
                    cnt_r <= 3'h0;
                end else begin
                    if (close_now) begin
                        open_r <= 1'b0;
                    end
                    if (b.sched_ev & hit) begin
                        cnt_r <= `CA_AUTO_CLOSE_CYC;
                    end else if (cnt_r != 3'h0) begin
                        cnt_r <= cnt_r - 3'h1;
                    end
                end
            end

            assign b.open_mask[g] = open_r;
        end
    endgenerate

    // Idle when no row is open anywhere
    assign b.all_idle = ~|b.open_mask;

endmodule // bank_tracker

//--- hw/sdram_cmd_addr_input_decode.sv
`timescale 1ns/1ps
`include "sdram_ca_defines.svh"

// How it works
// [RQ1] Sample all inputs on rising clock edge
// [RQ2] Clock gate high runs clocks, low stops
// [RQ3] Gate low: idle banks precharge down, else active
// [RQ4] Self-refresh exit seen without clock edge
// [RQ5] Controller keeps gate high during accesses
// [RQ6] Power-down keeps clock, termination, gate buffers
// [RQ7] Self refresh keeps only gate buffer
// [RQ8] Rank select high masks every command
// [RQ9] Termination request applies nominal termination
// [RQ10] Nominal termination disabled ignores the request
// [RQ11] Bank inputs pick bank or mode register
// [RQ12] Group inputs pick group; x16 one bit
// [RQ13] Activate takes mux pins as row 16-14
// [RQ14] Activate high: mux pins form command code
// [RQ15] Bit 10 schedules auto-close on access
// [RQ16] Precharge bit 10 closes one or all
// [RQ17] Bit 12 high full burst, low chopped
// [RQ18] Address is row, column or opcode
// [RQ19] Row bits 0-16, column bits 0-9
// [RQ20] Command encoding follows standard truth table
module sdram_cmd_addr_input_decode
    import ca_decode_pkg::*;
#(
    parameter bit X16 = 1'b0,
    parameter int ADDR_W = 14
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic cs_n,
    input wire logic activate_n,
    input wire logic row_strobe_or_row_bit16,
    input wire logic col_strobe_or_row_bit15,
    input wire logic write_en_or_row_bit14,
    input wire logic [ADDR_W-1:0] address_bus,
    input wire logic [1:0] bank_addr,
    input wire logic [1:0] bank_group_addr,
    input wire logic termination_request,
    output logic cmd_valid,
    output cmd_t cmd,
    output logic [1:0] bank_sel,
    output logic [1:0] group_sel,
    output logic [16:0] row_addr,
    output logic [9:0] col_addr,
    output logic [ADDR_W-1:0] mode_opcode,
    output logic [2:0] mode_reg_sel,
    output logic auto_close,
    output logic full_burst,
    output logic close_all,
    output pwr_t power_state,
    output logic clocks_running,
    output logic out_drv_en,
    output logic cmd_buf_en,
    output logic clk_buf_en,
    output logic odt_buf_en,
    output logic cke_buf_en,
    output logic nominal_termination,
    output logic term_tdqs_en
);

    // =================================================================
    // State
    logic cmd_valid_r;
    cmd_t cmd_r;
    logic [1:0] bank_r;
    logic [1:0] group_r;
    logic [16:0] row_r;
    logic [9:0] col_r;
    logic [ADDR_W-1:0] opcode_r;
    logic [2:0] mr_sel_r;
    logic auto_close_r;
    logic full_burst_r;
    logic close_all_r;
    pwr_t pwr_r;
    pwr_t pwr_nxt;
    logic [`CA_RTT_W-1:0] nominal_termination_r;
    logic tdqs_on_r;
    logic nom_term_r;

    bank_if bif ();

    bank_tracker #(
        .NBANK(`CA_NBANK)
    ) u_banks (
        .clk(clk),
        .nrst(nrst),
        .b(bif)
    );

    // =================================================================
    // Input decode
    wire [2:0] code = {row_strobe_or_row_bit16, col_strobe_or_row_bit15,
                       write_en_or_row_bit14};
    wire auto_close_bit = address_bus[`CA_AUTO_CLOSE_BIT];
    wire burst_chop_bit = address_bus[`CA_BURST_CHOP_BIT];
    wire awake = (pwr_r == PWR_ACTIVE) & clk_en;               // RQ6
    wire sel = awake & ~cs_n;                                    // RQ8
    wire is_act = sel & ~activate_n;                             // RQ13
    wire is_cmd = sel & activate_n;                              // RQ14
    wire [1:0] grp = X16 ? {1'b0, bank_group_addr[0]} : bank_group_addr; // RQ12
    wire [2:0] mr_sel = {bank_group_addr[0], bank_addr};         // RQ11
    wire sr_req = ~cs_n & activate_n & (code == `CA_CODE_REF);

    // Command code table
    wire cmd_t dec_cmd = is_act ? CMD_ACT :                      // RQ20
                         !is_cmd ? CMD_NONE :
                         (code == `CA_CODE_MRS) ? CMD_MRS :
                         (code == `CA_CODE_REF) ? CMD_REF :
                         (code == `CA_CODE_PRE) ? CMD_PRE :
                         (code == `CA_CODE_WR) ? CMD_WR :
                         (code == `CA_CODE_RD) ? CMD_RD :
                         (code == `CA_CODE_ZQ) ? CMD_ZQ :
                         (code == `CA_CODE_NOP) ? CMD_NOP : CMD_RSVD;
    wire is_access = (dec_cmd == CMD_RD) | (dec_cmd == CMD_WR);
    wire is_mr1 = (dec_cmd == CMD_MRS) & (mr_sel == `CA_MR1_SEL);

    // Bank tracker events
    assign bif.act_ev = is_act;
    assign bif.pre_ev = (dec_cmd == CMD_PRE);
    assign bif.pre_all = auto_close_bit;                         // RQ16
    assign bif.sched_ev = is_access & auto_close_bit;            // RQ15
    assign bif.idx = {grp, bank_addr};                           // RQ11

    // =================================================================
    // Command and address capture on the crossing edge
    always_ff @(posedge clk) begin                               // RQ1
        if (!nrst) begin
            cmd_valid_r <= 1'b0;
            cmd_r <= CMD_NONE;
        end else begin
            cmd_valid_r <= sel;
            cmd_r <= dec_cmd;
        end
    end

    // Field capture, qualified by a live command
    always_ff @(posedge clk) begin                               // RQ18
        if (!nrst) begin
            bank_r <= 2'h0;
            group_r <= 2'h0;
            row_r <= 17'h00000;
            col_r <= 10'h000;
            opcode_r <= '0;
            mr_sel_r <= 3'h0;
            auto_close_r <= 1'b0;
            full_burst_r <= 1'b0;
            close_all_r <= 1'b0;
        end else if (sel) begin
            bank_r <= bank_addr;
            group_r <= grp;
            row_r <= {code, address_bus[13:0]};                  // RQ19
            col_r <= address_bus[9:0];                           // RQ19
            opcode_r <= address_bus;
            mr_sel_r <= mr_sel;
            auto_close_r <= is_access & auto_close_bit;          // RQ15
            full_burst_r <= is_access & burst_chop_bit;          // RQ17
            close_all_r <= (dec_cmd == CMD_PRE) & auto_close_bit; // RQ16
        end
    end

    // =================================================================
    // Nominal termination mode held from writes to mode register one
    always_ff @(posedge clk) begin
        if (!nrst) begin
            nominal_termination_r <= '0;
            tdqs_on_r <= 1'b0;
        end else if (is_mr1) begin
            nominal_termination_r <= address_bus[`CA_RTT_LSB +: `CA_RTT_W];
            tdqs_on_r <= address_bus[`CA_TDQS_BIT];
        end
    end

    // Termination request, dropped while disabled or in self refresh
    wire nom_en = (nominal_termination_r != '0);
    wire term_req = termination_request & nom_en & odt_buf_en;   // RQ10

    always_ff @(posedge clk) begin                               // RQ9
        if (!nrst) begin
            nom_term_r <= 1'b0;
        end else begin
            nom_term_r <= term_req;
        end
    end

    // =================================================================
    // Power state from the clock-gating input
    always_comb begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            PWR_ACTIVE: begin
                if (!clk_en) begin                               // RQ3
                    if (bif.all_idle & sr_req) begin
                        pwr_nxt = PWR_SELF_REF;
                    end else if (bif.all_idle) begin
                        pwr_nxt = PWR_PRE_PD;
                    end else begin
                        pwr_nxt = PWR_ACT_PD;
                    end
                end
            end
            PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF: begin
                if (clk_en) begin
                    pwr_nxt = PWR_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pwr_r <= PWR_ACTIVE;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    // =================================================================
    // Clock, buffer and driver enables
    assign clocks_running = clk_en;                              // RQ2 RQ4
    assign out_drv_en = clk_en & (pwr_r == PWR_ACTIVE);          // RQ2
    assign cmd_buf_en = (pwr_r == PWR_ACTIVE);                   // RQ6 RQ7
    assign clk_buf_en = (pwr_r != PWR_SELF_REF);                 // RQ7
    assign odt_buf_en = (pwr_r != PWR_SELF_REF);                 // RQ7
    assign cke_buf_en = 1'b1;

    // =================================================================
    // Outputs
    assign cmd_valid = cmd_valid_r;
    assign cmd = cmd_r;
    assign bank_sel = bank_r;
    assign group_sel = group_r;
    assign row_addr = row_r;
    assign col_addr = col_r;
    assign mode_opcode = opcode_r;
    assign mode_reg_sel = mr_sel_r;
    assign auto_close = auto_close_r;
    assign full_burst = full_burst_r;
    assign close_all = close_all_r;
    assign power_state = pwr_r;
    assign nominal_termination = nom_term_r;
    assign term_tdqs_en = nom_term_r & tdqs_on_r & ~X16;         // RQ9

    // =================================================================
    // Checks
    sequence s_ap_issue;
        cmd_valid_r && (cmd_r == CMD_RD || cmd_r == CMD_WR) && auto_close_r;
    endsequence

    sequence s_bank_closed;
        ##[1:6] !bif.open_mask[{group_r, bank_r}];
    endsequence

    property p_ap_close;
        @(posedge clk) disable iff (!nrst)
        s_ap_issue |-> s_bank_closed;
    endproperty
    a_ap_close: assert property (p_ap_close) else $error("auto-close missed"); // RQ15

    property p_cs_mask;
        @(posedge clk) disable iff (!nrst)
        cs_n |=> !cmd_valid_r && cmd_r == CMD_NONE;
    endproperty
    a_cs_mask: assert property (p_cs_mask) else $error("masked command seen"); // RQ8

    property p_act_row;
        @(posedge clk) disable iff (!nrst)
        is_act |=> cmd_r == CMD_ACT && row_r[16:14] == $past(code)
            && row_r[13:0] == $past(address_bus[13:0]);
    endproperty
    a_act_row: assert property (p_act_row) else $error("activate row wrong"); // RQ13

    property p_mrs;
        @(posedge clk) disable iff (!nrst)
        (is_cmd && code == `CA_CODE_MRS) |=> cmd_r == CMD_MRS
            && mode_reg_sel == $past(mr_sel) && mode_opcode == $past(address_bus);
    endproperty
    a_mrs: assert property (p_mrs) else $error("mode register fields wrong"); // RQ11

    property p_burst;
        @(posedge clk) disable iff (!nrst)
        (is_cmd && (code == `CA_CODE_RD || code == `CA_CODE_WR))
            |=> full_burst_r == $past(burst_chop_bit) && col_r == $past(address_bus[9:0]);
    endproperty
    a_burst: assert property (p_burst) else $error("burst length wrong"); // RQ17

    property p_pre_all;
        @(posedge clk) disable iff (!nrst)
        (is_cmd && code == `CA_CODE_PRE && auto_close_bit) |=> bif.all_idle;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("banks left open"); // RQ16

    property p_pd_entry;
        @(posedge clk) disable iff (!nrst)
        (pwr_r == PWR_ACTIVE && !clk_en && !sr_req)
            |=> pwr_r == ($past(bif.all_idle) ? PWR_PRE_PD : PWR_ACT_PD);
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("power-down kind wrong"); // RQ3

    property p_pd_bufs;
        @(posedge clk) disable iff (!nrst)
        (pwr_r == PWR_PRE_PD || pwr_r == PWR_ACT_PD)
            |-> !cmd_buf_en && clk_buf_en && odt_buf_en && !out_drv_en;
    endproperty
    a_pd_bufs: assert property (p_pd_bufs) else $error("power-down buffers wrong"); // RQ6

    property p_sr_exit;
        @(posedge clk) disable iff (!nrst)
        (pwr_r == PWR_SELF_REF) |-> !cmd_buf_en && !odt_buf_en
            && clocks_running == clk_en ##1 (!$past(clk_en) || pwr_r == PWR_ACTIVE);
    endproperty
    a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit wrong"); // RQ7

    property p_odt_off;
        @(posedge clk) disable iff (!nrst)
        !nom_en |=> !nominal_termination;
    endproperty
    a_odt_off: assert property (p_odt_off) else $error("termination not ignored"); // RQ10

endmodule // sdram_cmd_addr_input_decode

//--- dv/ca_ctrl_model.sv
`timescale 1ns/1ps

// =====================================================================
// Controller side: drives command, address, gating and termination pins
module ca_ctrl_model (
    input wire logic clk,
    output logic clk_en,
    output logic cs_n,
    output logic open_n,
    output logic [2:0] code,
    output logic [13:0] addr,
    output logic [1:0] bnk,
    output logic [1:0] grp,
    output logic term_req
);
    // Power-up levels: gate on, rank deselected
    initial begin
        {clk_en, cs_n, open_n, code} = 6'h3F;
        {addr, bnk, grp, term_req} = 19'h0;
    end

    // One command cycle, then deselect with inverted pins so stale values never match
    task automatic issue(input logic sel_n, input logic o_n, input logic [2:0] c,
                         input logic [13:0] a, input logic [1:0] b, input logic [1:0] g);
        @(posedge clk);
        clk_en <= 1'b1;
        {cs_n, open_n, code} <= {sel_n, o_n, c};
        {addr, bnk, grp} <= {a, b, g};
        @(posedge clk);
        {cs_n, open_n, code} <= {2'b11, ~c};
        {addr, bnk, grp} <= {~a, ~b, ~g};
    endtask

    // Gate level change, with the command pins that go with it
    task automatic gate(input logic en, input logic [2:0] c, input logic sel_n);
        @(posedge clk);
        {clk_en, cs_n, open_n, code} <= {en, sel_n, 1'b1, c};
    endtask

    // Termination request level
    task automatic set_term(input logic v);
        @(posedge clk);
        term_req <= v;
    endtask
endmodule // ca_ctrl_model

//--- dv/sdram_cmd_addr_input_decode_test.sv
`timescale 1ns/1ps

// =====================================================================
// Self-checking bench for the command and address decoder
module sdram_cmd_addr_input_decode_test
    import ca_decode_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    wire logic clk_en, cs_n, open_n, term_req, cmd_valid, auto_close, full_burst, close_all;
    wire logic clocks_running, out_drv_en, cmd_buf_en, clk_buf_en, odt_buf_en, cke_buf_en;
    wire logic nom_term, tdqs_term;
    wire logic [2:0] code, mode_reg_sel;
    wire logic [13:0] addr, mode_opcode;
    wire logic [1:0] bnk, grp, bank_sel, group_sel;
    wire logic [16:0] row_addr;
    wire logic [9:0] col_addr;
    cmd_t cmd;
    pwr_t power_state;

    // 50 MHz clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            summarize();
        end
    end

    // =================================================================
    // Design and controller model
    sdram_cmd_addr_input_decode #(.X16(1'b0), .ADDR_W(14)) i_dut (
        .clk(clk), .nrst(nrst), .clk_en(clk_en), .cs_n(cs_n), .activate_n(open_n),
        .row_strobe_or_row_bit16(code[2]), .col_strobe_or_row_bit15(code[1]),
        .write_en_or_row_bit14(code[0]), .address_bus(addr), .bank_addr(bnk),
        .bank_group_addr(grp), .termination_request(term_req), .cmd_valid(cmd_valid),
        .cmd(cmd), .bank_sel(bank_sel), .group_sel(group_sel), .row_addr(row_addr),
        .col_addr(col_addr), .mode_opcode(mode_opcode), .mode_reg_sel(mode_reg_sel),
        .auto_close(auto_close), .full_burst(full_burst), .close_all(close_all),
        .power_state(power_state), .clocks_running(clocks_running), .out_drv_en(out_drv_en),
        .cmd_buf_en(cmd_buf_en), .clk_buf_en(clk_buf_en), .odt_buf_en(odt_buf_en),
        .cke_buf_en(cke_buf_en), .nominal_termination(nom_term), .term_tdqs_en(tdqs_term)
    );
    ca_ctrl_model i_ctrl (
        .clk(clk), .clk_en(clk_en), .cs_n(cs_n), .open_n(open_n), .code(code),
        .addr(addr), .bnk(bnk), .grp(grp), .term_req(term_req)
    );

    // =================================================================
    // Compare tasks
    task automatic chk_v(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_cmd(input cmd_t got, input cmd_t exp);
        chk_v(20'(got), 20'(exp));
    endtask
    task automatic chk_pwr(input pwr_t got, input pwr_t exp);
        chk_v(20'(got), 20'(exp));
    endtask

    // Raise the gate: clocks run at once, state follows one edge later
    task automatic wake(input pwr_t was);
        i_ctrl.gate(1'b1, 3'h7, 1'b1);
        #1;
        chk_v({clocks_running, out_drv_en}, 20'h2);
        chk_pwr(power_state, was);
        @(posedge clk);
        #1;
        chk_pwr(power_state, PWR_ACTIVE);
    endtask

    // =================================================================
    // Scenarios
    task automatic t_power();
        i_ctrl.gate(1'b0, 3'h7, 1'b1);
        #1;
        chk_v(clocks_running, 20'h0);
        @(posedge clk);
        #1;
        chk_pwr(power_state, PWR_PRE_PD);
        chk_v({cmd_buf_en, clk_buf_en, odt_buf_en, cke_buf_en, out_drv_en}, 20'h0E);
        wake(PWR_PRE_PD);
        i_ctrl.gate(1'b0, 3'h1, 1'b0);
        @(posedge clk);
        #1;
        chk_pwr(power_state, PWR_SELF_REF);
        chk_v({cmd_valid, cmd_buf_en, clk_buf_en, odt_buf_en, cke_buf_en}, 20'h01);
        wake(PWR_SELF_REF);
        i_ctrl.issue(1'b0, 1'b0, 3'h0, 14'h0001, 2'h1, 2'h2);
        i_ctrl.gate(1'b0, 3'h7, 1'b1);
        @(posedge clk);
        #1;
        chk_pwr(power_state, PWR_ACT_PD);
        wake(PWR_ACT_PD);
        $display("test power done");
    endtask

    task automatic t_pre();
        i_ctrl.issue(1'b0, 1'b1, 3'h2, 14'h0400, 2'h0, 2'h0);
        #1;
        chk_cmd(cmd, CMD_PRE);
        chk_v(close_all, 20'h1);
        i_ctrl.gate(1'b0, 3'h7, 1'b1);
        @(posedge clk);
        #1;
        chk_pwr(power_state, PWR_PRE_PD);
        wake(PWR_PRE_PD);
        i_ctrl.issue(1'b0, 1'b1, 3'h2, 14'h0000, 2'h3, 2'h2);
        #1;
        chk_v({close_all, bank_sel, group_sel}, 20'h0E);
        $display("test precharge done");
    endtask

    task automatic t_act();
        i_ctrl.issue(1'b0, 1'b0, 3'b101, 14'h2A5C, 2'h3, 2'h1);
        #1;
        chk_cmd(cmd, CMD_ACT);
        chk_v({cmd_valid, row_addr}, {3'h1, 3'b101, 14'h2A5C});
        chk_v({bank_sel, group_sel}, 20'hD);
        i_ctrl.issue(1'b1, 1'b0, 3'b010, 14'h1234, 2'h0, 2'h0);
        #1;
        chk_v({cmd_valid, row_addr}, {3'h0, 3'b101, 14'h2A5C});
        chk_cmd(cmd, CMD_NONE);
        $display("test activate done");
    endtask

    task automatic t_codes();
        cmd_t exp_cmd [8] = '{CMD_MRS, CMD_REF, CMD_PRE, CMD_RSVD,
                              CMD_WR, CMD_RD, CMD_ZQ, CMD_NOP};
        logic [13:0] a;
        for (int i = 0; i < 8; i++) begin
            a = {1'b0, i[0], 1'b0, i[2] ^ i[0], 10'h3C0 | 10'(i)};
            i_ctrl.issue(1'b0, 1'b1, 3'(i), a, 2'h2, 2'h0);
            #1;
            chk_cmd(cmd, exp_cmd[i]);
            if (i == 4 || i == 5) begin
                chk_v(auto_close, a[10]);
                chk_v(full_burst, a[12]);
                chk_v(col_addr, a[9:0]);
            end
        end
        $display("test codes done");
    endtask

    task automatic t_term();
        i_ctrl.set_term(1'b1);
        @(posedge clk);
        #1;
        chk_v(nom_term, 20'h0);
        i_ctrl.issue(1'b0, 1'b1, 3'h0, 14'h0900, 2'h1, 2'h0);
        #1;
        chk_cmd(cmd, CMD_MRS);
        chk_v({mode_reg_sel, mode_opcode}, {3'h0, 3'h1, 14'h0900});
        i_ctrl.issue(1'b0, 1'b1, 3'h0, 14'h0000, 2'h1, 2'h1);
        #1;
        chk_v(mode_reg_sel, 20'h5);
        @(posedge clk);
        #1;
        chk_v({nom_term, tdqs_term}, 20'h3);
        i_ctrl.set_term(1'b0);
        @(posedge clk);
        #1;
        chk_v(nom_term, 20'h0);
        $display("test termination done");
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        chk_pwr(power_state, PWR_ACTIVE);
        chk_cmd(cmd, CMD_NONE);
        t_power();
        t_pre();
        t_act();
        t_codes();
        t_term();
        summarize();
    end
endmodule // sdram_cmd_addr_input_decode_test
